/* File: hdl/rxoh_pkg.sv */
// shared constants and types for the receive overhead serial ports
package rxoh_pkg;
  // overhead bytes per frame on each port
  localparam int unsigned OW_BYTES      = 3;  // e1, f1, e2
  localparam int unsigned DCC_BYTES     = 3;  // d1, d2, d3
  localparam int unsigned POH_BYTES     = 9;  // j1 first
  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned OW_BITS       = OW_BYTES * BYTE_BITS;
  localparam int unsigned DCC_BITS      = DCC_BYTES * BYTE_BITS;
  localparam int unsigned POH_BITS      = POH_BYTES * BYTE_BITS;
  // overhead clock divider: half period in clk cycles (40 MHz / 8 = 5 MHz)
  localparam int unsigned OH_HALF_CYC   = 4;
  localparam logic [2:0]  OH_HALF_LAST  = 3'(OH_HALF_CYC - 1);
  localparam logic [6:0]  CNT_RST       = 7'h00;
  localparam logic [7:0]  OW_WORD_W     = 8'h18;
  localparam logic [7:0]  DCC_WORD_W    = 8'h18;
  localparam logic [7:0]  POH_WORD_W    = 8'h48;

  typedef enum logic [1:0] {
    RXOH_IDLE = 2'b00,
    RXOH_SEND = 2'b01
  } rxoh_state_e;
endpackage : rxoh_pkg

/* File: hdl/rxoh_if.sv */
// pins between the overhead output ports and the external receiver
`timescale 1ns/1ps
interface rxoh_if;
  logic overhead_out_clock;
  logic orderwire_data_out;
  logic orderwire_valid_out;
  logic orderwire_frame_pulse;
  logic section_dcc_data_out;
  logic section_dcc_valid_out;
  logic path_overhead_clock;
  logic path_overhead_data_out;
  logic path_overhead_frame_pulse;
  logic path_overhead_valid_out;

  modport dev (
    output overhead_out_clock,
    output orderwire_data_out,
    output orderwire_valid_out,
    output orderwire_frame_pulse,
    output section_dcc_data_out,
    output section_dcc_valid_out,
    output path_overhead_clock,
    output path_overhead_data_out,
    output path_overhead_frame_pulse,
    output path_overhead_valid_out
  );

  modport rcv (
    input overhead_out_clock,
    input orderwire_data_out,
    input orderwire_valid_out,
    input orderwire_frame_pulse,
    input section_dcc_data_out,
    input section_dcc_valid_out,
    input path_overhead_clock,
    input path_overhead_data_out,
    input path_overhead_frame_pulse,
    input path_overhead_valid_out
  );
endinterface : rxoh_if

/* File: hdl/rxoh_dev.sv */
// device end: serialises order-wire, section dcc and path overhead bytes
`timescale 1ns/1ps
module rxoh_dev (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // user side: one frame's bytes, loaded by a one-cycle strobe
  input  wire logic                          ow_load,
  input  wire logic [rxoh_pkg::OW_BITS-1:0]  ow_bytes,
  input  wire logic                          dcc_load,
  input  wire logic [rxoh_pkg::DCC_BITS-1:0] dcc_bytes,
  input  wire logic                          poh_load,
  input  wire logic [rxoh_pkg::POH_BITS-1:0] poh_bytes,
  output logic                               ow_busy,
  output logic                               dcc_busy,
  output logic                               poh_busy,
  rxoh_if.dev                                pins
);

  typedef struct packed {
    logic [2:0]                   div;
    logic                         oclk;
    rxoh_pkg::rxoh_state_e        ow_st;
    logic [6:0]                   ow_cnt;
    logic [rxoh_pkg::OW_BITS-1:0] ow_sh;
    logic                         ow_pend;
    logic [rxoh_pkg::OW_BITS-1:0] ow_buf;
    rxoh_pkg::rxoh_state_e        dcc_st;
    logic [6:0]                   dcc_cnt;
    logic [rxoh_pkg::DCC_BITS-1:0] dcc_sh;
    logic                         dcc_pend;
    logic [rxoh_pkg::DCC_BITS-1:0] dcc_buf;
    rxoh_pkg::rxoh_state_e        poh_st;
    logic [6:0]                   poh_cnt;
    logic [rxoh_pkg::POH_BITS-1:0] poh_sh;
    logic                         poh_pend;
    logic [rxoh_pkg::POH_BITS-1:0] poh_buf;
    logic                         ow_d;
    logic                         ow_v;
    logic                         ow_fp;
    logic                         dcc_d;
    logic                         dcc_v;
    logic                         poh_d;
    logic                         poh_v;
    logic                         poh_fp;
  } rxoh_dev_s;

  rxoh_dev_s st_q;
  rxoh_dev_s st_d;
  logic      fall;

  always_comb
  begin
    st_d = st_q;
    fall = 1'b0;
    // one shared divided clock serves both overhead clock pins
    if (st_q.div == rxoh_pkg::OH_HALF_LAST)
    begin
      st_d.div  = 3'h0;
      st_d.oclk = ~st_q.oclk;
      fall      = st_q.oclk;
    end
    else
    begin
      st_d.div = st_q.div + 3'h1;
    end
    // one frame may wait behind the one on the wire; a newer load overwrites
    if (ow_load)
    begin
      st_d.ow_pend = 1'b1;
      st_d.ow_buf  = ow_bytes;
    end
    if (dcc_load)
    begin
      st_d.dcc_pend = 1'b1;
      st_d.dcc_buf  = dcc_bytes;
    end
    if (poh_load)
    begin
      st_d.poh_pend = 1'b1;
      st_d.poh_buf  = poh_bytes;
    end
    if (fall)
    begin
      // order-wire port
      case (st_q.ow_st)
        rxoh_pkg::RXOH_IDLE:
        begin
          st_d.ow_v  = 1'b0;
          st_d.ow_fp = 1'b0;
          if (st_q.ow_pend)
          begin
            st_d.ow_pend = ow_load;
            st_d.ow_st   = rxoh_pkg::RXOH_SEND;
            st_d.ow_d    = st_q.ow_buf[rxoh_pkg::OW_BITS-1];
            st_d.ow_sh   = {st_q.ow_buf[rxoh_pkg::OW_BITS-2:0], 1'b0};
            st_d.ow_v    = 1'b1;
            st_d.ow_fp   = 1'b1;
            st_d.ow_cnt  = 7'h01;
          end
        end
        rxoh_pkg::RXOH_SEND:
        begin
          st_d.ow_fp = 1'b0;
          if (st_q.ow_cnt == rxoh_pkg::OW_WORD_W[6:0])
          begin
            st_d.ow_st = rxoh_pkg::RXOH_IDLE;
            st_d.ow_v  = 1'b0;
          end
          else
          begin
            st_d.ow_d   = st_q.ow_sh[rxoh_pkg::OW_BITS-1];
            st_d.ow_sh  = {st_q.ow_sh[rxoh_pkg::OW_BITS-2:0], 1'b0};
            st_d.ow_cnt = st_q.ow_cnt + 7'h01;
          end
        end
        default:
        begin
          st_d.ow_st = rxoh_pkg::RXOH_IDLE;
          st_d.ow_v  = 1'b0;
        end
      endcase
      // section dcc port
      case (st_q.dcc_st)
        rxoh_pkg::RXOH_IDLE:
        begin
          st_d.dcc_v = 1'b0;
          if (st_q.dcc_pend)
          begin
            st_d.dcc_pend = dcc_load;
            st_d.dcc_st   = rxoh_pkg::RXOH_SEND;
            st_d.dcc_d    = st_q.dcc_buf[rxoh_pkg::DCC_BITS-1];
            st_d.dcc_sh   = {st_q.dcc_buf[rxoh_pkg::DCC_BITS-2:0], 1'b0};
            st_d.dcc_v    = 1'b1;
            st_d.dcc_cnt  = 7'h01;
          end
        end
        rxoh_pkg::RXOH_SEND:
        begin
          if (st_q.dcc_cnt == rxoh_pkg::DCC_WORD_W[6:0])
          begin
            st_d.dcc_st = rxoh_pkg::RXOH_IDLE;
            st_d.dcc_v  = 1'b0;
          end
          else
          begin
            st_d.dcc_d   = st_q.dcc_sh[rxoh_pkg::DCC_BITS-1];
            st_d.dcc_sh  = {st_q.dcc_sh[rxoh_pkg::DCC_BITS-2:0], 1'b0};
            st_d.dcc_cnt = st_q.dcc_cnt + 7'h01;
          end
        end
        default:
        begin
          st_d.dcc_st = rxoh_pkg::RXOH_IDLE;
          st_d.dcc_v  = 1'b0;
        end
      endcase
      // path overhead port
      case (st_q.poh_st)
        rxoh_pkg::RXOH_IDLE:
        begin
          st_d.poh_v  = 1'b0;
          st_d.poh_fp = 1'b0;
          if (st_q.poh_pend)
          begin
            st_d.poh_pend = poh_load;
            st_d.poh_st   = rxoh_pkg::RXOH_SEND;
            st_d.poh_d    = st_q.poh_buf[rxoh_pkg::POH_BITS-1];
            st_d.poh_sh   = {st_q.poh_buf[rxoh_pkg::POH_BITS-2:0], 1'b0};
            st_d.poh_v    = 1'b1;
            st_d.poh_fp   = 1'b1;
            st_d.poh_cnt  = 7'h01;
          end
        end
        rxoh_pkg::RXOH_SEND:
        begin
          st_d.poh_fp = 1'b0;
          if (st_q.poh_cnt == rxoh_pkg::POH_WORD_W[6:0])
          begin
            st_d.poh_st = rxoh_pkg::RXOH_IDLE;
            st_d.poh_v  = 1'b0;
          end
          else
          begin
            st_d.poh_d   = st_q.poh_sh[rxoh_pkg::POH_BITS-1];
            st_d.poh_sh  = {st_q.poh_sh[rxoh_pkg::POH_BITS-2:0], 1'b0};
            st_d.poh_cnt = st_q.poh_cnt + 7'h01;
          end
        end
        default:
        begin
          st_d.poh_st = rxoh_pkg::RXOH_IDLE;
          st_d.poh_v  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign pins.overhead_out_clock        = st_q.oclk;
  assign pins.path_overhead_clock       = st_q.oclk;
  assign pins.orderwire_data_out        = st_q.ow_d;
  assign pins.orderwire_valid_out       = st_q.ow_v;
  assign pins.orderwire_frame_pulse     = st_q.ow_fp;
  assign pins.section_dcc_data_out      = st_q.dcc_d;
  assign pins.section_dcc_valid_out     = st_q.dcc_v;
  assign pins.path_overhead_data_out    = st_q.poh_d;
  assign pins.path_overhead_valid_out   = st_q.poh_v;
  assign pins.path_overhead_frame_pulse = st_q.poh_fp;
  assign ow_busy  = st_q.ow_pend;
  assign dcc_busy = st_q.dcc_pend;
  assign poh_busy = st_q.poh_pend;

endmodule : rxoh_dev

/* File: hdl/rxoh_rcv.sv */
// receiver end: samples the overhead pins on rising clock edges
`timescale 1ns/1ps
module rxoh_rcv (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  rxoh_if.rcv                                pins,
  output logic                               ow_bit_stb,
  output logic                               ow_bit,
  output logic                               ow_start,
  output logic                               dcc_bit_stb,
  output logic                               dcc_bit,
  output logic                               poh_bit_stb,
  output logic                               poh_bit,
  output logic                               poh_start
);

  // pin inputs pass a two-stage synchroniser; stage one feeds stage two only
  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
    logic       oclk_prev;
    logic       pclk_prev;
    logic       ow_run;
    logic       ow_stb;
    logic       ow_b;
    logic       ow_st;
    logic       dcc_stb;
    logic       dcc_b;
    logic       poh_stb;
    logic       poh_b;
    logic       poh_st;
  } rxoh_rcv_s;

  rxoh_rcv_s st_q;
  rxoh_rcv_s st_d;
  logic      o_rise;
  logic      p_rise;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = {pins.overhead_out_clock, pins.orderwire_data_out, pins.orderwire_valid_out,
               pins.orderwire_frame_pulse, pins.section_dcc_data_out,
               pins.section_dcc_valid_out, pins.path_overhead_clock,
               pins.path_overhead_data_out, pins.path_overhead_frame_pulse,
               pins.path_overhead_valid_out};
    st_d.s2 = st_q.s1;
    st_d.oclk_prev = st_q.s2[9];
    st_d.pclk_prev = st_q.s2[3];
    o_rise = st_q.s2[9] & ~st_q.oclk_prev;
    p_rise = st_q.s2[3] & ~st_q.pclk_prev;
    st_d.ow_stb  = 1'b0;
    st_d.ow_st   = 1'b0;
    st_d.dcc_stb = 1'b0;
    st_d.poh_stb = 1'b0;
    st_d.poh_st  = 1'b0;
    if (o_rise)
    begin
      if (st_q.s2[7] && st_q.s2[6])
      begin
        st_d.ow_run = 1'b1;
        st_d.ow_st  = 1'b1;
        st_d.ow_stb = 1'b1;
        st_d.ow_b   = st_q.s2[8];
      end
      else if (st_q.ow_run && st_q.s2[7])
      begin
        st_d.ow_stb = 1'b1;
        st_d.ow_b   = st_q.s2[8];
      end
      else if (!st_q.s2[7])
      begin
        st_d.ow_run = 1'b0;
      end
      if (st_q.s2[4])
      begin
        st_d.dcc_stb = 1'b1;
        st_d.dcc_b   = st_q.s2[5];
      end
    end
    if (p_rise && st_q.s2[0])
    begin
      st_d.poh_stb = 1'b1;
      st_d.poh_b   = st_q.s2[2];
      st_d.poh_st  = st_q.s2[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign ow_bit_stb  = st_q.ow_stb;
  assign ow_bit      = st_q.ow_b;
  assign ow_start    = st_q.ow_st;
  assign dcc_bit_stb = st_q.dcc_stb;
  assign dcc_bit     = st_q.dcc_b;
  assign poh_bit_stb = st_q.poh_stb;
  assign poh_bit     = st_q.poh_b;
  assign poh_start   = st_q.poh_st;

endmodule : rxoh_rcv

/* File: verification/rxoh_sva.sv */
// concurrent checks on the overhead port pins
`timescale 1ns/1ps
module rxoh_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic overhead_out_clock,
  input wire logic orderwire_data_out,
  input wire logic orderwire_valid_out,
  input wire logic orderwire_frame_pulse,
  input wire logic section_dcc_data_out,
  input wire logic section_dcc_valid_out,
  input wire logic path_overhead_clock,
  input wire logic path_overhead_data_out,
  input wire logic path_overhead_frame_pulse,
  input wire logic path_overhead_valid_out
);
  typedef struct packed {
    logic [9:0] ow;
    logic [9:0] dcc;
    logic [9:0] poh;
  } rxoh_span_s;

  rxoh_span_s span_q;
  rxoh_span_s span_d;

  // run length of each valid strobe, cleared as soon as it drops
  always_comb
  begin
    span_d.ow  = orderwire_valid_out ? span_q.ow + 10'h001 : 10'h000;
    span_d.dcc = section_dcc_valid_out ? span_q.dcc + 10'h001 : 10'h000;
    span_d.poh = path_overhead_valid_out ? span_q.poh + 10'h001 : 10'h000;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      span_q <= '0;
    else
      span_q <= span_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ow_edge_only: assert property (
    $changed({orderwire_data_out, orderwire_valid_out, orderwire_frame_pulse})
    |-> $fell(overhead_out_clock)) else $error("order-wire pin moved off falling edge");
  a_dcc_edge_only: assert property (
    $changed({section_dcc_data_out, section_dcc_valid_out})
    |-> $fell(overhead_out_clock)) else $error("dcc pin moved off falling edge");
  a_poh_edge_only: assert property (
    $changed({path_overhead_data_out, path_overhead_valid_out, path_overhead_frame_pulse})
    |-> $fell(path_overhead_clock)) else $error("path pin moved off falling edge");
  a_frame_one_period: assert property (
    $rose(orderwire_frame_pulse) |-> orderwire_frame_pulse[*8] ##1 !orderwire_frame_pulse)
    else $error("frame pulse not one clock period");
  a_ow_frame_first: assert property (
    $rose(orderwire_valid_out) |-> $rose(orderwire_frame_pulse))
    else $error("frame pulse missing on first bit");
  a_ow_valid_span: assert property (
    $fell(orderwire_valid_out) |-> span_q.ow == 10'h0c0)
    else $error("order-wire valid span wrong");
  a_dcc_valid_span: assert property (
    $fell(section_dcc_valid_out) |-> span_q.dcc == 10'h0c0)
    else $error("dcc valid span wrong");
  a_poh_valid_span: assert property (
    $fell(path_overhead_valid_out) |-> span_q.poh == 10'h240)
    else $error("path valid span wrong");
  a_poh_frame_j1: assert property (
    $rose(path_overhead_valid_out) |-> $rose(path_overhead_frame_pulse))
    else $error("path frame pulse missing on j1");
endmodule : rxoh_sva

/* File: verification/rx_overhead_serial_ports_tb_top.sv */
// self-checking bench: device end facing receiver end
`timescale 1ns/1ps
module rx_overhead_serial_ports_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ow_load = 1'b0;
  logic        dcc_load = 1'b0;
  logic        poh_load = 1'b0;
  logic [23:0] ow_bytes = 24'h0;
  logic [23:0] dcc_bytes = 24'h0;
  logic [71:0] poh_bytes = 72'h0;
  logic        ow_busy, dcc_busy, poh_busy;
  logic        ow_bit_stb, ow_bit, ow_start, dcc_bit_stb, dcc_bit;
  logic        poh_bit_stb, poh_bit, poh_start;
  logic        qr[3][$];
  logic        qw[3][$];
  int          sr[3][$];
  int          sw[3][$];
  logic [71:0] ex[3];
  int          nb[3] = '{24, 24, 72};
  int          miscompares = 0;
  int          check_count = 0;

  always #12.5 clk = ~clk;

  rxoh_if ifc ();
  rxoh_dev u_rxoh_dev (.clk(clk), .rst(rst), .ce(1'b1), .ow_load(ow_load),
    .ow_bytes(ow_bytes), .dcc_load(dcc_load), .dcc_bytes(dcc_bytes), .poh_load(poh_load),
    .poh_bytes(poh_bytes), .ow_busy(ow_busy), .dcc_busy(dcc_busy), .poh_busy(poh_busy),
    .pins(ifc.dev));
  rxoh_rcv u_rxoh_rcv (.clk(clk), .rst(rst), .ce(1'b1), .pins(ifc.rcv),
    .ow_bit_stb(ow_bit_stb), .ow_bit(ow_bit), .ow_start(ow_start), .dcc_bit_stb(dcc_bit_stb),
    .dcc_bit(dcc_bit), .poh_bit_stb(poh_bit_stb), .poh_bit(poh_bit), .poh_start(poh_start));
  rxoh_sva u_rxoh_sva (.clk(clk), .rst(rst), .overhead_out_clock(ifc.overhead_out_clock),
    .orderwire_data_out(ifc.orderwire_data_out), .orderwire_valid_out(ifc.orderwire_valid_out),
    .orderwire_frame_pulse(ifc.orderwire_frame_pulse),
    .section_dcc_data_out(ifc.section_dcc_data_out),
    .section_dcc_valid_out(ifc.section_dcc_valid_out),
    .path_overhead_clock(ifc.path_overhead_clock),
    .path_overhead_data_out(ifc.path_overhead_data_out),
    .path_overhead_frame_pulse(ifc.path_overhead_frame_pulse),
    .path_overhead_valid_out(ifc.path_overhead_valid_out));

  always @(posedge clk)
  begin
    if (ow_start) sr[0].push_back(qr[0].size());
    if (poh_start) sr[2].push_back(qr[2].size());
    if (ow_bit_stb) qr[0].push_back(ow_bit);
    if (dcc_bit_stb) qr[1].push_back(dcc_bit);
    if (poh_bit_stb) qr[2].push_back(poh_bit);
  end

  // the wire itself, sampled where an outside receiver would sample it
  always @(posedge ifc.overhead_out_clock)
  begin
    if (ifc.orderwire_frame_pulse) sw[0].push_back(qw[0].size());
    if (ifc.orderwire_valid_out) qw[0].push_back(ifc.orderwire_data_out);
    if (ifc.section_dcc_valid_out) qw[1].push_back(ifc.section_dcc_data_out);
  end

  always @(posedge ifc.path_overhead_clock)
  begin
    if (ifc.path_overhead_frame_pulse) sw[2].push_back(qw[2].size());
    if (ifc.path_overhead_valid_out) qw[2].push_back(ifc.path_overhead_data_out);
  end

  function automatic logic [71:0] pack(input logic q[$]);
    logic [71:0] v;
    v = 72'h0;
    foreach (q[i]) v = {v[70:0], q[i]};
    return v;
  endfunction : pack

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (ifc.overhead_out_clock !== v && n < 20)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_pin

  // loads all ports; dbl reloads order-wire and path before the frame starts
  task automatic send(input logic [71:0] a, input logic [71:0] b, input bit dbl);
    int n;
    for (int p = 0; p < 3; p++)
    begin
      qr[p].delete();
      qw[p].delete();
      sr[p].delete();
      sw[p].delete();
    end
    // just after a pin clock fall, so the reload lands before the next start
    wait_pin(1'b1);
    wait_pin(1'b0);
    {ow_bytes, dcc_bytes, poh_bytes} = {a[23:0], a[71:48], a};
    {ow_load, dcc_load, poh_load} = 3'h7;
    ex[0] = 72'(a[23:0]);
    ex[1] = 72'(a[71:48]);
    ex[2] = a;
    @(negedge clk);
    if (dbl)
    begin
      {ow_bytes, poh_bytes, dcc_load} = {b[23:0], b, 1'b0};
      ex[0] = 72'(b[23:0]);
      ex[2] = b;
      @(negedge clk);
    end
    {ow_load, dcc_load, poh_load} = 3'h0;
    @(negedge clk);
    chk("busy", 72'h7, 72'({ow_busy, dcc_busy, poh_busy}));
    n = 0;
    while (n < 2000 && (ow_busy | dcc_busy | poh_busy | ifc.orderwire_valid_out
           | ifc.section_dcc_valid_out | ifc.path_overhead_valid_out) !== 1'b0)
    begin
      @(negedge clk);
      n++;
    end
    repeat (16) @(negedge clk);
    chk("frame end", 72'h0, 72'(n >= 2000));
    for (int p = 0; p < 3; p++)
    begin
      chk($sformatf("rcv bits %0d", p), ex[p], pack(qr[p]));
      chk($sformatf("wire bits %0d", p), ex[p], pack(qw[p]));
      chk($sformatf("rcv count %0d", p), 72'(nb[p]), 72'(qr[p].size()));
      chk($sformatf("wire count %0d", p), 72'(nb[p]), 72'(qw[p].size()));
      if (p != 1)
      begin
        chk($sformatf("rcv start %0d", p), 72'h0, 72'(sr[p].size() > 0 ? sr[p][0] : -1));
        chk($sformatf("wire frame %0d", p), 72'h0, 72'(sw[p].size() > 0 ? sw[p][0] : -1));
      end
    end
    chk("ow frame count", 72'h1, 72'(sw[0].size()));
  endtask : send

  function automatic logic [71:0] rnd();
    return 72'({$urandom, $urandom, $urandom});
  endfunction : rnd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #400000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32973));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    send({72{1'b1}}, 72'h0, 1'b1);
    for (int k = 0; k < 4; k++)
      send(rnd(), rnd(), k[0]);
    wrap_up();
  end
endmodule : rx_overhead_serial_ports_tb_top
